// [spcr_defs.svh]
/*
 * Register indices, field positions, reset values and rate figures for the
 * sync power result and CCA rate control register bank.
 * Assumes it is included by bare name, once or more, from design files.
 */
`ifndef SPCR_DEFS_SVH
`define SPCR_DEFS_SVH

// Register indices; byte address is four times the index
`define SPCR_IDX_FINE       10'h158
`define SPCR_IDX_COARSE     10'h15a
`define SPCR_IDX_CCA        10'h15e
`define SPCR_IDX_STATUS     10'h15c
`define SPCR_IDX_W          10

// Reset values
`define SPCR_FINE_RST       10'h200
`define SPCR_COARSE_RST     8'h80
`define SPCR_CCA_RST        8'h00

// Widths of the two result fields
`define SPCR_FINE_W         10
`define SPCR_COARSE_W       8

// CCA rate control field positions
`define SPCR_OVR_BIT        0
`define SPCR_MIDX_BIT       1
`define SPCR_RATE_LSB       2
`define SPCR_RATE_MSB       5
`define SPCR_OPT_LSB        6
`define SPCR_OPT_MSB        7

// Status register field positions
`define SPCR_ST_LEGAL_BIT   8
`define SPCR_ST_SEL_LSB     16
`define SPCR_ST_LAST_LSB    24

// FSK rates in units of 100 bps
`define SPCR_RATE_50K       16'h01f4
`define SPCR_RATE_100K      16'h03e8
`define SPCR_RATE_150K      16'h05dc
`define SPCR_RATE_200K      16'h07d0
`define SPCR_RATE_10K       16'h0064
`define SPCR_RATE_20K       16'h00c8
`define SPCR_RATE_9K6       16'h0060
`define SPCR_RATE_19K2      16'h00c0
`define SPCR_RATE_38K4      16'h0180
`define SPCR_RATE_115K2     16'h0480

// AHB encodings used by the slave
`define SPCR_HSIZE_WORD     3'b010
`define SPCR_HRESP_OKAY     1'b0

`endif

// [spcr_pkg.sv]
/*
 * Types shared by the sync power and CCA rate register bank.
 * Assumes nothing of its surroundings; used only by scoped reference.
 */
package spcr_pkg;

    // OFDM option selected by the two-bit option code
    typedef enum logic [1:0] {
        spcr_opt_1,
        spcr_opt_2,
        spcr_opt_3,
        spcr_opt_4
    } spcr_ofdm_opt_t;

    // FSK modulation index: 0.5 or 1.0
    typedef enum logic {
        spcr_mi_half,
        spcr_mi_one
    } spcr_mod_idx_t;

    typedef logic [3:0] spcr_rate_code_t;

    // Bus front end phases
    typedef enum logic [1:0] {
        spcr_ph_idle,
        spcr_ph_write,
        spcr_ph_read
    } spcr_phase_t;

endpackage

// [spcr_rate_decode.sv]
/*
 * Decodes a four-bit FSK rate code into a rate in units of 100 bps and
 * flags codes that software must never write.
 * Assumes the code comes from a register on the same clock.
 */
`timescale 1ns/1ps
`include "spcr_defs.svh"

module spcr_rate_decode
(
    input  wire spcr_pkg::spcr_rate_code_t code,
    output logic [15:0]                     rate_x100,
    output logic                            legal
);

    // Prohibited codes read as zero rate so nothing downstream is misled
    always_comb
    begin
        legal = 1'b1;
        unique case (code)
            4'h0:    rate_x100 = `SPCR_RATE_50K;
            4'h1:    rate_x100 = `SPCR_RATE_100K;
            4'h2:    rate_x100 = `SPCR_RATE_150K;
            4'h3:    rate_x100 = `SPCR_RATE_200K;
            4'h4:    rate_x100 = `SPCR_RATE_10K;
            4'h5:    rate_x100 = `SPCR_RATE_20K;
            4'h8:    rate_x100 = `SPCR_RATE_9K6;
            4'h9:    rate_x100 = `SPCR_RATE_19K2;
            4'ha:    rate_x100 = `SPCR_RATE_38K4;
            4'hb:    rate_x100 = `SPCR_RATE_115K2;
            default:
            begin
                rate_x100 = 16'h0000;
                legal     = 1'b0;
            end
        endcase
    end

endmodule

// [spcr_ahb_front.sv]
/*
 * AHB-Lite slave front end: turns address phases into read strobes and
 * write strobes, always ready, always OKAY.
 * Assumes a single master, whole-word single transfers, one clock.
 */
`timescale 1ns/1ps
`include "spcr_defs.svh"

module spcr_ahb_front
(
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic                           rd_en,
    output logic [`SPCR_IDX_W-1:0]         rd_idx,
    output logic                           wr_en,
    output logic [`SPCR_IDX_W-1:0]         wr_idx
);

    spcr_pkg::spcr_phase_t phase;
    logic                  accept;
    logic                  word_ok;

    // Only aligned whole words inside the low 4 KB window are decoded
    assign accept  = hsel & hready & htrans[1];
    assign word_ok = (hsize == `SPCR_HSIZE_WORD) && (haddr[1:0] == 2'b00)
                     && (haddr[31:12] == 20'h00000);
    assign rd_en   = accept & ~hwrite & word_ok;
    assign rd_idx  = haddr[11:2];
    assign wr_en   = (phase == spcr_pkg::spcr_ph_write);

    // Track the data phase; writes land one cycle after their address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase  <= spcr_pkg::spcr_ph_idle;
            wr_idx <= '0;
        end
        else if (accept)
        begin
            phase  <= (hwrite && word_ok) ? spcr_pkg::spcr_ph_write
                                          : spcr_pkg::spcr_ph_read;
            wr_idx <= haddr[11:2];
        end
        else if (hready)
        begin
            phase  <= spcr_pkg::spcr_ph_idle;
        end
    end

    // Zero wait states, so the ready and response flops never move
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= `SPCR_HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= `SPCR_HRESP_OKAY;
        end
    end

endmodule

// [spcr_regs.sv]
/*
 * Sync power result and CCA rate control register bank. Stores the
 * synchronization-section power per receive save bank, serves both result
 * registers for the selected bank, feeds the receive level filter and
 * selects the data rate settings that clear channel assessment uses.
 * Assumes measurement, bank select and tx/rx rate inputs come from logic
 * on hclk, and an AHB-Lite master with whole-word single transfers.
 */
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "spcr_defs.svh"

module spcr_regs
#(
    parameter int NUM_BANKS = 2,
    parameter int BANK_W    = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1
)
(
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic [31:0]                     hrdata,
    output logic                            hresp,
    input  wire logic                       meas_valid,
    input  wire logic [BANK_W-1:0]          meas_bank,
    input  wire logic [`SPCR_FINE_W-1:0]    meas_fine,
    input  wire logic [BANK_W-1:0]          bank_select,
    input  wire spcr_pkg::spcr_rate_code_t  txrx_fsk_rate_code,
    input  wire spcr_pkg::spcr_mod_idx_t    txrx_mod_index_sel,
    input  wire spcr_pkg::spcr_ofdm_opt_t   txrx_ofdm_option_code,
    output logic [`SPCR_FINE_W-1:0]         level_filter_power,
    output logic                            level_filter_valid,
    output spcr_pkg::spcr_rate_code_t       cca_eff_rate_code,
    output spcr_pkg::spcr_mod_idx_t         cca_eff_mod_index,
    output spcr_pkg::spcr_ofdm_opt_t        cca_eff_ofdm_option,
    output logic [15:0]                     cca_eff_rate_x100,
    output logic                            cca_eff_rate_legal
);

    // Bus strobes from the front end
    logic                        rd_en;
    logic [`SPCR_IDX_W-1:0]      rd_idx;
    logic                        wr_en;
    logic [`SPCR_IDX_W-1:0]      wr_idx;

    // Per-bank result store
    logic [`SPCR_FINE_W-1:0]     fine_mem   [NUM_BANKS];
    logic [`SPCR_COARSE_W-1:0]   coarse_mem [NUM_BANKS];
    logic [BANK_W-1:0]           last_bank;

    // CCA rate control register and its fields
    logic [7:0]                  cca_rate_control;
    logic                        cca_rate_override;
    logic                        cca_mod_index_sel;
    spcr_pkg::spcr_rate_code_t   cca_fsk_rate_code;
    spcr_pkg::spcr_ofdm_opt_t    cca_ofdm_option_code;

    // Effective CCA settings before the output flops
    spcr_pkg::spcr_rate_code_t   next_rate_code;
    spcr_pkg::spcr_mod_idx_t     next_mod_index;
    spcr_pkg::spcr_ofdm_opt_t    next_ofdm_option;
    logic [15:0]                 next_rate_x100;
    logic                        next_rate_legal;

    // Value the control register will hold after a write in this cycle
    logic [7:0]                  cca_view;
    logic [31:0]                 next_rdata;

    // Halve the half-dBm value, rounding toward minus infinity, then clamp
    // into the 8-bit range; floor keeps 33DH (-97.5) at 9EH (-98)
    function automatic logic [`SPCR_COARSE_W-1:0] fine_to_coarse
    (
        input logic [`SPCR_FINE_W-1:0] fine
    );
        logic signed [`SPCR_FINE_W-1:0] half;
        half = $signed(fine) >>> 1;
        if (half > 10'sd127)
        begin
            fine_to_coarse = 8'h7f;
        end
        else if (half < -10'sd128)
        begin
            fine_to_coarse = 8'h80;
        end
        else
        begin
            fine_to_coarse = half[`SPCR_COARSE_W-1:0];
        end
    endfunction

    // Word decode shared by the read path and the write path
    function automatic logic idx_hit
    (
        input logic [`SPCR_IDX_W-1:0] idx,
        input logic [`SPCR_IDX_W-1:0] reg_idx
    );
        idx_hit = (idx == reg_idx);
    endfunction

    spcr_ahb_front u_front
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rd_en     (rd_en),
        .rd_idx    (rd_idx),
        .wr_en     (wr_en),
        .wr_idx    (wr_idx)
    );

    // Store each new measurement in its save bank; coarse copy is derived
    // here once so both registers always describe the same frame
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                fine_mem[b]   <= `SPCR_FINE_RST;
                coarse_mem[b] <= `SPCR_COARSE_RST;
            end
        end
        else if (meas_valid)
        begin
            fine_mem[meas_bank]   <= meas_fine;
            coarse_mem[meas_bank] <= fine_to_coarse(meas_fine);
        end
    end

    // Remember which bank was written last, shown in the status word
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            last_bank <= '0;
        end
        else if (meas_valid)
        begin
            last_bank <= meas_bank;
        end
    end

    // Level filter sees every fresh value, not the bank chosen for reads
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            level_filter_power <= `SPCR_FINE_RST;
            level_filter_valid <= 1'b0;
        end
        else
        begin
            level_filter_valid <= meas_valid;
            if (meas_valid)
            begin
                level_filter_power <= meas_fine;
            end
        end
    end

    // Software-owned control register; only whole-word writes reach it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cca_rate_control <= `SPCR_CCA_RST;
        end
        else if (wr_en && idx_hit(wr_idx, `SPCR_IDX_CCA))
        begin
            cca_rate_control <= hwdata[7:0];
        end
    end

    // Field split of the control register
    assign cca_rate_override    = cca_rate_control[`SPCR_OVR_BIT];
    assign cca_mod_index_sel    = cca_rate_control[`SPCR_MIDX_BIT];
    assign cca_fsk_rate_code    = cca_rate_control[`SPCR_RATE_MSB:`SPCR_RATE_LSB];
    assign cca_ofdm_option_code =
        spcr_pkg::spcr_ofdm_opt_t'(cca_rate_control[`SPCR_OPT_MSB:`SPCR_OPT_LSB]);

    // Pick the settings clear channel assessment runs with
    always_comb
    begin
        if (cca_rate_override)
        begin
            next_rate_code   = cca_fsk_rate_code;
            next_mod_index   = spcr_pkg::spcr_mod_idx_t'(cca_mod_index_sel);
            next_ofdm_option = cca_ofdm_option_code;
        end
        else
        begin
            next_rate_code   = txrx_fsk_rate_code;
            next_mod_index   = txrx_mod_index_sel;
            next_ofdm_option = txrx_ofdm_option_code;
        end
    end

    // Rate figure of the chosen code; prohibited codes raise no alarm,
    // they read as zero rate and drop the legal flag for the consumer to act on
    spcr_rate_decode u_rate
    (
        .code      (next_rate_code),
        .rate_x100 (next_rate_x100),
        .legal     (next_rate_legal)
    );

    // Outputs to the CCA engine are flopped; they trail a write by one cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cca_eff_rate_code   <= 4'h0;
            cca_eff_mod_index   <= spcr_pkg::spcr_mi_half;
            cca_eff_ofdm_option <= spcr_pkg::spcr_opt_1;
            cca_eff_rate_x100   <= `SPCR_RATE_50K;
            cca_eff_rate_legal  <= 1'b1;
        end
        else
        begin
            cca_eff_rate_code   <= next_rate_code;
            cca_eff_mod_index   <= next_mod_index;
            cca_eff_ofdm_option <= next_ofdm_option;
            cca_eff_rate_x100   <= next_rate_x100;
            cca_eff_rate_legal  <= next_rate_legal;
        end
    end

    // A read may sit in the data phase of a write to the same register;
    // forwarding the write data keeps read-after-write coherent
    assign cca_view = (wr_en && idx_hit(wr_idx, `SPCR_IDX_CCA)) ? hwdata[7:0]
                                                                : cca_rate_control;

    // Read mux; unmapped words read zero with an OKAY response
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (idx_hit(rd_idx, `SPCR_IDX_FINE))
        begin
            next_rdata[`SPCR_FINE_W-1:0] = fine_mem[bank_select];
        end
        else if (idx_hit(rd_idx, `SPCR_IDX_COARSE))
        begin
            next_rdata[`SPCR_COARSE_W-1:0] = coarse_mem[bank_select];
        end
        else if (idx_hit(rd_idx, `SPCR_IDX_CCA))
        begin
            next_rdata[7:0] = cca_view;
        end
        else if (idx_hit(rd_idx, `SPCR_IDX_STATUS))
        begin
            next_rdata[`SPCR_OVR_BIT]                = cca_rate_override;
            next_rdata[`SPCR_MIDX_BIT]               = cca_eff_mod_index;
            next_rdata[`SPCR_RATE_MSB:`SPCR_RATE_LSB] = cca_eff_rate_code;
            next_rdata[`SPCR_OPT_MSB:`SPCR_OPT_LSB]   = cca_eff_ofdm_option;
            next_rdata[`SPCR_ST_LEGAL_BIT]           = cca_eff_rate_legal;
            next_rdata[`SPCR_ST_SEL_LSB +: BANK_W]   = bank_select;
            next_rdata[`SPCR_ST_LAST_LSB +: BANK_W]  = last_bank;
        end
    end

    // Read data is sampled at the address phase and stands in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            hrdata <= next_rdata;
        end
    end

endmodule

// [spcr_regs_assertions.sv]
/*
 * Concurrent checks on the ports of the sync power and CCA rate bank.
 * Assumes one AHB-Lite master of whole words and a bind into spcr_regs.
 */
`timescale 1ns/1ps
`include "spcr_defs.svh"

module spcr_regs_assertions
(
    input wire logic                      hclk,
    input wire logic                      hresetn,
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic [2:0]                hsize,
    input wire logic [31:0]               hwdata,
    input wire logic                      hready,
    input wire logic                      hreadyout,
    input wire logic [31:0]               hrdata,
    input wire logic                      hresp,
    input wire logic                      meas_valid,
    input wire logic [`SPCR_FINE_W-1:0]   meas_fine,
    input wire spcr_pkg::spcr_rate_code_t txrx_fsk_rate_code,
    input wire spcr_pkg::spcr_mod_idx_t   txrx_mod_index_sel,
    input wire spcr_pkg::spcr_ofdm_opt_t  txrx_ofdm_option_code,
    input wire logic [`SPCR_FINE_W-1:0]   level_filter_power,
    input wire logic                      level_filter_valid,
    input wire spcr_pkg::spcr_rate_code_t cca_eff_rate_code,
    input wire spcr_pkg::spcr_mod_idx_t   cca_eff_mod_index,
    input wire spcr_pkg::spcr_ofdm_opt_t  cca_eff_ofdm_option,
    input wire logic [15:0]               cca_eff_rate_x100,
    input wire logic                      cca_eff_rate_legal
);
    localparam logic [31:0] FINE_A   = {20'h00000, `SPCR_IDX_FINE, 2'b00};
    localparam logic [31:0] COARSE_A = {20'h00000, `SPCR_IDX_COARSE, 2'b00};
    localparam logic [31:0] CCA_A    = {20'h00000, `SPCR_IDX_CCA, 2'b00};
    logic       up;
    logic       wr_pend;
    logic [7:0] ctl;
    wire        take = hsel && hready && htrans[1] && hsize == `SPCR_HSIZE_WORD;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Shadow of the control register; up masks the first edge after reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            up      <= 1'b0;
            wr_pend <= 1'b0;
            ctl     <= `SPCR_CCA_RST;
        end
        else
        begin
            up      <= 1'b1;
            wr_pend <= take && hwrite && haddr == CCA_A;
            if (wr_pend)
                ctl <= hwdata[7:0];
        end
    end

    // Mux outputs lag the control register and tx/rx inputs by one edge
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    lf_strobe_a: assert property (meas_valid |=> level_filter_valid
        && level_filter_power == $past(meas_fine)) else $error("level filter strobe wrong");
    lf_single_a: assert property (level_filter_valid |-> $past(meas_valid))
        else $error("level filter strobe without measurement");
    cca_code_a: assert property (up |-> cca_eff_rate_code ==
        $past(ctl[0] ? ctl[5:2] : txrx_fsk_rate_code)) else $error("cca rate code wrong");
    cca_index_a: assert property (up |-> cca_eff_mod_index ==
        $past(ctl[0] ? ctl[1] : txrx_mod_index_sel)) else $error("cca index wrong");
    cca_option_a: assert property (up |-> cca_eff_ofdm_option ==
        $past(ctl[0] ? ctl[7:6] : txrx_ofdm_option_code)) else $error("cca option wrong");
    rate_legal_a: assert property (cca_eff_rate_legal ==
        !(cca_eff_rate_code inside {4'h6, 4'h7, [4'hc:4'hf]})) else $error("legal flag wrong");
    prohib_rate_a: assert property (!cca_eff_rate_legal |-> cca_eff_rate_x100 == 16'h0000)
        else $error("prohibited code gives a rate");
    fine_upper_a: assert property (take && !hwrite && haddr == FINE_A
        |=> hrdata[31:10] == 22'h000000) else $error("fine result upper bits set");
    coarse_upper_a: assert property (take && !hwrite && haddr == COARSE_A
        |=> hrdata[31:8] == 24'h000000) else $error("coarse result upper bits set");
endmodule

bind spcr_regs spcr_regs_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .meas_valid, .meas_fine,
    .txrx_fsk_rate_code, .txrx_mod_index_sel, .txrx_ofdm_option_code, .level_filter_power,
    .level_filter_valid, .cca_eff_rate_code, .cca_eff_mod_index, .cca_eff_ofdm_option,
    .cca_eff_rate_x100, .cca_eff_rate_legal);

// [sync_power_cca_rate_regs_bench.sv]
/*
 * Self-checking bench for the sync power and CCA rate register bank.
 * Assumes two save banks and a bus master that waits on hreadyout.
 */
`timescale 1ns/1ps
`include "spcr_defs.svh"

module sync_power_cca_rate_regs_bench;
    localparam logic [31:0] A_FINE = {20'h00000, `SPCR_IDX_FINE, 2'b00};
    localparam logic [31:0] A_CRS  = {20'h00000, `SPCR_IDX_COARSE, 2'b00};
    localparam logic [31:0] A_CCA  = {20'h00000, `SPCR_IDX_CCA, 2'b00};
    logic                      hclk;
    logic                      hresetn;
    logic                      hsel;
    logic [31:0]               haddr;
    logic [1:0]                htrans;
    logic                      hwrite;
    logic [31:0]               hwdata;
    logic                      hreadyout;
    logic [31:0]               hrdata;
    logic                      hresp;
    logic                      meas_valid;
    logic [0:0]                meas_bank;
    logic [0:0]                bank_select;
    logic [9:0]                meas_fine;
    spcr_pkg::spcr_rate_code_t txrx_rate;
    spcr_pkg::spcr_mod_idx_t   txrx_idx;
    spcr_pkg::spcr_ofdm_opt_t  txrx_opt;
    logic [9:0]                lf_power;
    logic                      lf_valid;
    spcr_pkg::spcr_rate_code_t eff_code;
    spcr_pkg::spcr_mod_idx_t   eff_idx;
    spcr_pkg::spcr_ofdm_opt_t  eff_opt;
    logic [15:0]               eff_rate;
    logic                      eff_legal;
    int                        n_errors;
    int                        tests_run;
    int                        cycles;

    spcr_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(`SPCR_HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .meas_valid(meas_valid), .meas_bank(meas_bank), .meas_fine(meas_fine),
        .bank_select(bank_select), .txrx_fsk_rate_code(txrx_rate),
        .txrx_mod_index_sel(txrx_idx), .txrx_ofdm_option_code(txrx_opt),
        .level_filter_power(lf_power), .level_filter_valid(lf_valid),
        .cca_eff_rate_code(eff_code), .cca_eff_mod_index(eff_idx),
        .cca_eff_ofdm_option(eff_opt), .cca_eff_rate_x100(eff_rate),
        .cca_eff_rate_legal(eff_legal));

    // Free-running 100 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Hang guard, far above the roughly 120 cycles the run needs
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One single transfer; no cycle count assumed, hreadyout decides
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wr ? wd : ~wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h00000000, v);
        check(name, v, exp);
    endtask

    // Expected rate in 100 bps units; zero marks a prohibited code
    function automatic logic [15:0] rate_of(input logic [3:0] c);
        case (c)
            4'h0: return `SPCR_RATE_50K;
            4'h1: return `SPCR_RATE_100K;
            4'h2: return `SPCR_RATE_150K;
            4'h3: return `SPCR_RATE_200K;
            4'h4: return `SPCR_RATE_10K;
            4'h5: return `SPCR_RATE_20K;
            4'h8: return `SPCR_RATE_9K6;
            4'h9: return `SPCR_RATE_19K2;
            4'ha: return `SPCR_RATE_38K4;
            4'hb: return `SPCR_RATE_115K2;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic meas(input logic [0:0] b, input logic [9:0] v);
        meas_valid <= 1'b1;
        meas_bank <= b;
        meas_fine <= v;
        @(posedge hclk);
        meas_valid <= 1'b0;
        #1;
        check("lf_valid", lf_valid, 1'b1);
        check("lf_power", lf_power, v);
        @(posedge hclk);
    endtask

    task automatic t_reset();
        bank_select <= 1'b1;
        rd_chk("fine_rst", A_FINE, 32'h00000200);
        rd_chk("coarse_rst", A_CRS, 32'h00000080);
        rd_chk("ctrl_rst", A_CCA, 32'h00000000);
        rd_chk("unmapped", 32'h00000574, 32'h00000000);
        check("eff_follow", eff_code, txrx_rate);
    endtask

    // Saturation corners of the coarse value, banks alternating
    task automatic t_results();
        logic [9:0] fv [5] = '{10'h33d, 10'h1ff, 10'h200, 10'h3ff, 10'h0c8};
        logic [7:0] cv [5] = '{8'h9e, 8'h7f, 8'h80, 8'hff, 8'h64};
        logic [31:0] v;
        for (int i = 0; i < 5; i++)
        begin
            meas(i[0], fv[i]);
            bank_select <= i[0];
            rd_chk("fine", A_FINE, {22'h000000, fv[i]});
            rd_chk("coarse", A_CRS, {24'h000000, cv[i]});
        end
        bus(1'b1, A_FINE, 32'hffffffff, v);
        rd_chk("fine_ro", A_FINE, 32'h000000c8);
        bank_select <= 1'b1;
        rd_chk("bank1", A_CRS, 32'h000000ff);
    endtask

    task automatic t_cca();
        logic [31:0] d;
        logic [31:0] v;
        for (int c = 0; c < 16; c++)
        begin
            d = {24'h000000, c[1:0], c[3:0], c[2], 1'b1};
            bus(1'b1, A_CCA, d, v);
            rd_chk("ctrl", A_CCA, d);
            check("eff_code", eff_code, c[3:0]);
            check("eff_rate", eff_rate, rate_of(c[3:0]));
            check("eff_legal", eff_legal, rate_of(c[3:0]) != 16'h0000);
            check("eff_idx", eff_idx, c[2]);
            check("eff_opt", eff_opt, c[1:0]);
        end
        bus(1'b1, A_CCA, 32'h000000fe, v);
        txrx_rate <= 4'h3;
        txrx_idx <= spcr_pkg::spcr_mi_half;
        txrx_opt <= spcr_pkg::spcr_opt_2;
        repeat (2) @(posedge hclk);
        #1;
        check("follow_code", eff_code, 4'h3);
        check("follow_rate", eff_rate, `SPCR_RATE_200K);
        check("follow_idx", eff_idx, spcr_pkg::spcr_mi_half);
        check("follow_opt", eff_opt, spcr_pkg::spcr_opt_2);
        // Status word: eff code 3, option 2, legal, bank_select 1, last bank 0
        rd_chk("status", 32'h00000570, 32'h0001014c);
    endtask

    // Main sequence: reset for two cycles, then each scenario in turn
    initial
    begin
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        meas_valid = 1'b0;
        meas_bank = 1'b0;
        meas_fine = 10'h000;
        bank_select = 1'b0;
        txrx_rate = 4'h9;
        txrx_idx = spcr_pkg::spcr_mi_one;
        txrx_opt = spcr_pkg::spcr_opt_3;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_results();
        t_cca();
        finish_test();
    end
endmodule
